/* rtl/serializer_map.svh */
`ifndef SERIALIZER_MAP_SVH
`define SERIALIZER_MAP_SVH

// ****************************************************************
// word and lane geometry
// ****************************************************************
`define WORD_WIDTH      28
`define LANE_COUNT      4
`define SLOT_COUNT      7
`define SLOT_LAST       3'h6

// forwarded clock level per slot, slot 0 in bit 6
`define FWD_CLK_PATTERN 7'h63

// ****************************************************************
// timing
// ****************************************************************
`define SYS_CLK_PERIOD_NS 50
`define LOCK_TIME_NS      10000000
`define LOCK_CYCLES       (`LOCK_TIME_NS / `SYS_CLK_PERIOD_NS)
`define SLEEP_ENTRY_NS    100

// ****************************************************************
// reset values
// ****************************************************************
`define EDGE_SELECT_RESET 1'b0

`endif

/* rtl/serializer_pkg.sv */
`default_nettype none
package serializer_pkg;

  // pixel side warm-up sequence
  typedef enum logic [0:0] {
    WARMUP,
    RUNNING
  } lock_state_type;

  typedef logic [2:0]  slot_index_type;
  typedef logic [27:0] pixel_word_type;
  typedef logic [6:0]  lane_slots_type;

endpackage : serializer_pkg

`default_nettype wire

/* rtl/parallel_to_lvds_serializer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serializer_map.svh"

module parallel_to_lvds_serializer
  import serializer_pkg::*;
#(
  parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    link_clk,
  input  wire logic [`WORD_WIDTH-1:0]  parallel_pixel_in,
  input  wire logic                    edge_select,
  input  wire logic                    sleep_n,
  output var  logic [`LANE_COUNT-1:0]  serial_lane_out,
  output var  logic [`LANE_COUNT-1:0]  serial_lane_oe,
  output var  logic                    forwarded_clock_out,
  output var  logic                    forwarded_clock_oe,
  output var  logic                    lock_done
);

  // ****************************************************************
  // lane slot map
  // ****************************************************************

  // word bit sent in a given lane and slot, slot 0 first after edge
  function automatic logic [4:0] slot_bit(input logic [1:0] lane,
                                          input slot_index_type slot);
    logic [4:0] idx;
    idx = 5'h00;
    case (lane)
      2'h3: case (slot)
        3'h0: idx = 5'h1b; 3'h1: idx = 5'h17; 3'h2: idx = 5'h11;
        3'h3: idx = 5'h10; 3'h4: idx = 5'h0b; 3'h5: idx = 5'h0a;
        default: idx = 5'h05;
      endcase
      2'h2: case (slot)
        3'h0: idx = 5'h1a; 3'h1: idx = 5'h19; 3'h2: idx = 5'h18;
        3'h3: idx = 5'h16; 3'h4: idx = 5'h15; 3'h5: idx = 5'h14;
        default: idx = 5'h13;
      endcase
      2'h1: case (slot)
        3'h0: idx = 5'h12; 3'h1: idx = 5'h0f; 3'h2: idx = 5'h0e;
        3'h3: idx = 5'h0d; 3'h4: idx = 5'h0c; 3'h5: idx = 5'h09;
        default: idx = 5'h08;
      endcase
      default: case (slot)
        3'h0: idx = 5'h07; 3'h1: idx = 5'h06; 3'h2: idx = 5'h04;
        3'h3: idx = 5'h03; 3'h4: idx = 5'h02; 3'h5: idx = 5'h01;
        default: idx = 5'h00;
      endcase
    endcase
    return idx;
  endfunction : slot_bit

  // ****************************************************************
  // pixel domain: pin synchronisers
  // ****************************************************************
  logic       edge_meta_q;
  logic       edge_sync_q;
  logic       sleep_meta_q;
  logic       sleep_sync_q;
  logic       ack_meta_q;
  logic       ack_sync_q;
  logic       ack_tgl_q;

  // straps and the returning ack cross in through two stages;
  // reset value of the strap is falling edge, as with the pull-down
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_meta_q  <= `EDGE_SELECT_RESET;
      edge_sync_q  <= `EDGE_SELECT_RESET;
      sleep_meta_q <= 1'b0;
      sleep_sync_q <= 1'b0;
      ack_meta_q   <= 1'b0;
      ack_sync_q   <= 1'b0;
    end else begin
      edge_meta_q  <= edge_select;
      edge_sync_q  <= edge_meta_q;
      sleep_meta_q <= sleep_n;
      sleep_sync_q <= sleep_meta_q;
      ack_meta_q   <= ack_tgl_q;
      ack_sync_q   <= ack_meta_q;
    end
  end

  // ****************************************************************
  // pixel domain: capture on either edge
  // ****************************************************************
  pixel_word_type rise_word_q;
  pixel_word_type fall_word_q;

  // both edges are captured; the strap picks which one is used
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_word_q <= '0;
    end else begin
      rise_word_q <= parallel_pixel_in;
    end
  end

  always_ff @(negedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_word_q <= '0;
    end else begin
      fall_word_q <= parallel_pixel_in;
    end
  end

  // ****************************************************************
  // pixel domain: lock timer and word hand-off
  // ****************************************************************
  lock_state_type lock_state_q;
  lock_state_type lock_state_d;
  logic [31:0]    lock_cnt_q;
  logic [31:0]    lock_cnt_d;
  pixel_word_type hold_word_q;
  pixel_word_type hold_word_d;
  logic           req_tgl_q;
  logic           req_tgl_d;

  // a word is only offered when the link side has taken the last
  // one; a slow link clock therefore drops pixels, never tears them
  always_comb begin
    lock_state_d = lock_state_q;
    lock_cnt_d   = lock_cnt_q;
    hold_word_d  = hold_word_q;
    req_tgl_d    = req_tgl_q;
    case (lock_state_q)
      WARMUP: begin
        if (lock_cnt_q >= 32'(LOCK_CYCLES - 1)) begin
          lock_state_d = RUNNING;
        end else begin
          lock_cnt_d = lock_cnt_q + 32'h1;
        end
      end
      default: begin
        if (req_tgl_q == ack_sync_q) begin
          hold_word_d = edge_sync_q ? rise_word_q : fall_word_q;
          req_tgl_d   = ~req_tgl_q;
        end
      end
    endcase
    // asleep: stop and wait for lock again on wake
    if (!sleep_sync_q) begin
      lock_state_d = WARMUP;
      lock_cnt_d   = 32'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_state_q <= WARMUP;
      lock_cnt_q   <= 32'h0;
      hold_word_q  <= '0;
      req_tgl_q    <= 1'b0;
    end else begin
      lock_state_q <= lock_state_d;
      lock_cnt_q   <= lock_cnt_d;
      hold_word_q  <= hold_word_d;
      req_tgl_q    <= req_tgl_d;
    end
  end

  assign lock_done = (lock_state_q == RUNNING);

  // ****************************************************************
  // link domain: reset release and synchronisers
  // ****************************************************************
  logic link_rst_meta_q;
  logic link_rst_n_q;
  logic req_meta_q;
  logic req_sync_q;
  logic lsleep_meta_q;
  logic lsleep_sync_q;
  logic lock_meta_q;
  logic lock_sync_q;

  // reset asserts at once and is released on a link edge
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_meta_q <= 1'b0;
      link_rst_n_q    <= 1'b0;
    end else begin
      link_rst_meta_q <= 1'b1;
      link_rst_n_q    <= link_rst_meta_q;
    end
  end

  // sleep goes through two fast link stages to meet entry time
  always_ff @(posedge link_clk or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      req_meta_q    <= 1'b0;
      req_sync_q    <= 1'b0;
      lsleep_meta_q <= 1'b0;
      lsleep_sync_q <= 1'b0;
      lock_meta_q   <= 1'b0;
      lock_sync_q   <= 1'b0;
    end else begin
      req_meta_q    <= req_tgl_q;
      req_sync_q    <= req_meta_q;
      lsleep_meta_q <= sleep_n;
      lsleep_sync_q <= lsleep_meta_q;
      lock_meta_q   <= lock_done;
      lock_sync_q   <= lock_meta_q;
    end
  end

  // ****************************************************************
  // link domain: slot counter and lane shifters
  // ****************************************************************
  slot_index_type slot_q;
  slot_index_type slot_d;
  lane_slots_type lane_slots_q [`LANE_COUNT];
  lane_slots_type lane_slots_d [`LANE_COUNT];
  logic           ack_tgl_d;
  logic           active;

  assign active = lsleep_sync_q && lock_sync_q;

  // each lane is reloaded on the last slot so the new word starts
  // exactly with the forwarded clock frame
  always_comb begin
    slot_d    = slot_q;
    ack_tgl_d = ack_tgl_q;
    for (int l = 0; l < `LANE_COUNT; l++) begin
      lane_slots_d[l] = lane_slots_q[l];
    end
    if (!active) begin
      slot_d = 3'h0;
    end else if (slot_q == `SLOT_LAST) begin
      slot_d = 3'h0;
      if (req_sync_q != ack_tgl_q) begin
        ack_tgl_d = req_sync_q;
        for (int l = 0; l < `LANE_COUNT; l++) begin
          for (int s = 0; s < `SLOT_COUNT; s++) begin
            lane_slots_d[l][s] =
              hold_word_q[slot_bit(2'(l), 3'(s))];
          end
        end
      end
    end else begin
      slot_d = slot_q + 3'h1;
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      slot_q    <= 3'h0;
      ack_tgl_q <= 1'b0;
      for (int l = 0; l < `LANE_COUNT; l++) begin
        lane_slots_q[l] <= 7'h00;
      end
    end else begin
      slot_q    <= slot_d;
      ack_tgl_q <= ack_tgl_d;
      for (int l = 0; l < `LANE_COUNT; l++) begin
        lane_slots_q[l] <= lane_slots_d[l];
      end
    end
  end

  // ****************************************************************
  // link domain: output stage
  // ****************************************************************
  logic [`LANE_COUNT-1:0] lane_out_d;
  logic                   fwd_clk_d;
  logic [`SLOT_COUNT-1:0] fwd_pattern;

  assign fwd_pattern = `FWD_CLK_PATTERN;

  // quiet low until locked; drivers off while asleep; slot 0 is
  // read from the reloaded lanes, else it leaks the previous word
  always_comb begin
    lane_out_d = '0;
    fwd_clk_d  = 1'b0;
    if (active) begin
      for (int l = 0; l < `LANE_COUNT; l++) begin
        lane_out_d[l] = lane_slots_d[l][slot_d];
      end
      fwd_clk_d = fwd_pattern[3'h6 - slot_d];
    end
  end

  always_ff @(posedge link_clk or negedge link_rst_n_q) begin
    if (!link_rst_n_q) begin
      serial_lane_out     <= '0;
      serial_lane_oe      <= '0;
      forwarded_clock_out <= 1'b0;
      forwarded_clock_oe  <= 1'b0;
    end else begin
      serial_lane_out     <= lane_out_d;
      serial_lane_oe      <= {`LANE_COUNT{lsleep_sync_q}};
      forwarded_clock_out <= fwd_clk_d;
      forwarded_clock_oe  <= lsleep_sync_q;
    end
  end

endmodule : parallel_to_lvds_serializer

`default_nettype wire

/* tb/serializer_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// lock, sleep and frame checks
// ****************************************
module serializer_monitor #(
  parameter int LOCK_CYCLES = 8
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        link_clk,
  input wire logic [27:0] parallel_pixel_in,
  input wire logic        edge_select,
  input wire logic        sleep_n,
  input wire logic [3:0]  serial_lane_out,
  input wire logic [3:0]  serial_lane_oe,
  input wire logic        forwarded_clock_out,
  input wire logic        forwarded_clock_oe,
  input wire logic        lock_done
);
  // slack of five covers the sleep synchroniser
  localparam int LATE = LOCK_CYCLES + 5;
  int awake_q;
  // awake time in pixel cycles, saturating
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) awake_q <= 0;
    else awake_q <= sleep_n ? awake_q + int'(awake_q < LATE) : 0;
  end
  a_lock_not_early: assert property (@(posedge sys_clk)
    disable iff (!rst_n) $rose(lock_done) |-> awake_q >= LOCK_CYCLES)
    else $error("lock too early");
  a_lock_not_late: assert property (@(posedge sys_clk)
    disable iff (!rst_n) awake_q == LATE |-> lock_done)
    else $error("lock too late");
  a_lock_holds: assert property (@(posedge sys_clk)
    disable iff (!rst_n) lock_done && sleep_n |=> lock_done)
    else $error("lock lost while awake");
  a_sleep_drops_lock: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !sleep_n [*4] |-> !lock_done)
    else $error("lock kept in sleep");
  a_sleep_quiets: assert property (@(posedge link_clk)
    disable iff (!rst_n) $fell(sleep_n) |-> ##[1:6]
    (serial_lane_oe == 4'h0 && !forwarded_clock_oe))
    else $error("outputs driven after sleep");
  a_awake_drives: assert property (@(posedge link_clk)
    disable iff (!rst_n) sleep_n [*6] |->
    (serial_lane_oe == 4'hf && forwarded_clock_oe))
    else $error("outputs released while awake");
  a_quiet_unlocked: assert property (@(posedge link_clk)
    disable iff (!rst_n) (sleep_n && !lock_done) [*5] |->
    (serial_lane_out == 4'h0 && !forwarded_clock_out))
    else $error("lanes active before lock");
  a_clock_pattern: assert property (@(posedge link_clk)
    disable iff (!rst_n || !sleep_n) $fell(forwarded_clock_out) |->
    !forwarded_clock_out [*3] ##1 forwarded_clock_out [*4]
    ##1 !forwarded_clock_out)
    else $error("forwarded clock off pattern");
  c_lock: cover property (@(posedge sys_clk) $rose(lock_done));
  c_sleep: cover property (@(posedge link_clk) $fell(sleep_n));
  c_frame: cover property (@(posedge link_clk) $fell(forwarded_clock_out));
endmodule : serializer_monitor
bind parallel_to_lvds_serializer serializer_monitor #(
  .LOCK_CYCLES(LOCK_CYCLES)) serializer_monitor_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
  .parallel_pixel_in(parallel_pixel_in), .edge_select(edge_select),
  .sleep_n(sleep_n), .serial_lane_out(serial_lane_out),
  .serial_lane_oe(serial_lane_oe),
  .forwarded_clock_out(forwarded_clock_out),
  .forwarded_clock_oe(forwarded_clock_oe), .lock_done(lock_done));
`default_nettype wire

/* tb/lvds_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// receiving end of the link
// ****************************************
module lvds_rx_model (
  input  wire logic        link_clk,
  input  wire logic [3:0]  lane_pin,
  input  wire logic        fwd_pin,
  output var  logic [27:0] word_seen
);
  logic [6:0] sh [4];
  logic [6:0] clk_hist;
  // slot 0 lands in bit 6 once a frame is in
  always @(posedge link_clk) begin
    clk_hist <= {clk_hist[5:0], fwd_pin};
    for (int l = 0; l < 4; l++) sh[l] <= {sh[l][5:0], lane_pin[l]};
  end
  // frame boundary taken from the clock shape, bit map mirrors sender
  always @(posedge link_clk) begin
    if (clk_hist == 7'h63) word_seen <= {sh[3][6], sh[2][6:4], sh[3][5],
      sh[2][3:0], sh[1][6], sh[3][4:3], sh[1][5:2], sh[3][2:1],
      sh[1][1:0], sh[0][6:5], sh[3][0], sh[0][4:0]};
  end
endmodule : lvds_rx_model
`default_nettype wire

/* tb/parallel_to_lvds_serializer_test.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// serializer bench
// ****************************************
module parallel_to_lvds_serializer_test;
  import serializer_pkg::*;
  typedef struct {
    pixel_word_type hi;
    pixel_word_type lo;
    logic           sel;
    pixel_word_type exp;
  } row_type;
  localparam int LOCK = 8;
  // expected word: low phase on a rising strobe, high phase on falling
  row_type        rows [4] = '{
    '{28'h5555555, 28'haaaaaaa, 1'b1, 28'haaaaaaa},
    '{28'h0123456, 28'hfedcba9, 1'b0, 28'h0123456},
    '{28'h8000001, 28'h7fffffe, 1'b1, 28'h7fffffe},
    '{28'h0f0f0f0, 28'hf0f0f0f, 1'b0, 28'h0f0f0f0}};
  logic           sys_clk = 1'b0;
  logic           link_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           edge_select = 1'b0;
  logic           sleep_n = 1'b1;
  pixel_word_type parallel_pixel_in = '0;
  logic [3:0]     lane_out;
  logic [3:0]     lane_oe;
  logic           fwd_clk;
  logic           fwd_oe;
  logic           lock_done;
  wire  [3:0]     lane_pin;
  wire            fwd_pin;
  pixel_word_type word_seen;
  int             err_total = 0;
  int             samples_checked = 0;
  int             cycles = 0;
  logic           watch = 1'b0;
  pixel_word_type word_old = '0;
  pixel_word_type word_new = '0;
  // pixel clock at the slow end of its range
  always #25 sys_clk = ~sys_clk;
  // offset so link edges drift against pixel edges
  initial begin
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  // released pins float
  for (genvar i = 0; i < 4; i++) begin : g_pin
    assign lane_pin[i] = lane_oe[i] ? lane_out[i] : 1'bz;
  end
  assign fwd_pin = fwd_oe ? fwd_clk : 1'bz;
  parallel_to_lvds_serializer #(.LOCK_CYCLES(LOCK))
    parallel_to_lvds_serializer_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
    .parallel_pixel_in(parallel_pixel_in), .edge_select(edge_select),
    .sleep_n(sleep_n), .serial_lane_out(lane_out),
    .serial_lane_oe(lane_oe), .forwarded_clock_out(fwd_clk),
    .forwarded_clock_oe(fwd_oe), .lock_done(lock_done));
  lvds_rx_model lvds_rx_model_i (.link_clk(link_clk),
    .lane_pin(lane_pin), .fwd_pin(fwd_pin), .word_seen(word_seen));
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // while watched, every frame seen is the old word or the new, whole
  always @(word_seen) begin
    if (watch) begin
      check(word_seen, (word_seen === word_old) ? word_old : word_new);
    end
  end
  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : idle
  // one value per clock phase, so the strobe edge picks which is sent
  task automatic drive(input pixel_word_type hi, input pixel_word_type lo,
                       input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1 parallel_pixel_in = hi;
      @(negedge sys_clk);
      #1 parallel_pixel_in = lo;
    end
  endtask : drive
  // hang guard, run needs about 160 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    idle(6);
    rst_n = 1'b1;
    idle(3);
    check(lock_done, 1'b0);
    check({fwd_clk, lane_out}, 5'h00);
    check({fwd_oe, lane_oe}, 5'h1f);
    idle(LOCK + 6);
    check(lock_done, 1'b1);
    foreach (rows[r]) begin
      edge_select = rows[r].sel;
      drive(rows[r].hi, rows[r].lo, 16);
      check(word_seen, rows[r].exp);
    end
    // sleep in mid-stream, then wake and relock
    idle(1);
    sleep_n = 1'b0;
    #100;
    check({fwd_oe, lane_oe}, 5'h00);
    idle(5);
    check(lock_done, 1'b0);
    sleep_n = 1'b1;
    idle(3);
    check(lock_done, 1'b0);
    edge_select = 1'b0;
    drive(28'h1234567, 28'h7654321, LOCK + 16);
    check(lock_done, 1'b1);
    check(word_seen, 28'h1234567);
    // word change: no frame may mix bits of two words
    word_old = 28'h1234567;
    word_new = 28'h0abcdef;
    watch = 1'b1;
    drive(28'h0abcdef, 28'h7654321, 16);
    watch = 1'b0;
    check(word_seen, 28'h0abcdef);
    // reset in mid-stream: all outputs drop at once, lock restarts
    idle(1);
    rst_n = 1'b0;
    #1;
    check({lock_done, fwd_oe, lane_oe, fwd_clk, lane_out}, 11'h000);
    idle(2);
    rst_n = 1'b1;
    idle(3);
    check(lock_done, 1'b0);
    check({fwd_oe, lane_oe}, 5'h1f);
    idle(LOCK + 6);
    check(lock_done, 1'b1);
    stop_test();
  end
endmodule : parallel_to_lvds_serializer_test
`default_nettype wire
